// >>> adc_parallel_sample_output_tb_top.sv
`timescale 1ns/1ps
`include "adcpo_regs.vh"
`define ADCPO_CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module adc_parallel_sample_output_tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cpos = 1'b0;
  logic accept = 1'b1;
  logic checking = 1'b0;
  logic [15:0] ain_p = 16'h0000;
  logic [15:0] ain_n = 16'h0000;
  logic [3:0] ph = 4'h0;
  logic [3:0] hi_cyc = 4'h8;
  logic [15:0] exp_v;
  logic [15:0] exp_q[$];
  wire [`ADCPO_WORD_W-1:0] word;
  wire [`ADCPO_WORD_W-1:0] cap_word;
  wire flag, strobe, duty, drop, ready, cap_flag;
  int cap_n;
  int bad_count = 0;
  int num_checks = 0;
  // ****
  // Clocks and expected samples.
  // ****
  always #2.5 i_mclk = ~i_mclk;
  // The conversion clock is built from the system clock so that it moves on its edges.
  always @(posedge i_mclk) begin
    ph <= ph + 4'h1;
    cpos <= (ph < hi_cyc);
  end
  always @(posedge cpos) if (checking) exp_q.push_back(expv(ain_p, ain_n));
  always @(cap_n) if (checking) begin
    `ADCPO_CHK("latency", 4, exp_q.size())
    exp_v = exp_q.pop_front();
    `ADCPO_CHK("word", exp_v[14:0], cap_word)
    `ADCPO_CHK("flag", exp_v[15], cap_flag)
  end
  adcpo_top adcpo_top_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_conv_clock_pos(cpos), .i_conv_clock_neg(~cpos),
    .i_analog_in_pos(ain_p), .i_analog_in_neg(ain_n), .i_capture_ready(ready),
    .o_sample_word(word), .o_overrange_flag(flag), .o_sample_valid_strobe(strobe),
    .o_duty_fault(duty), .o_sample_dropped(drop)
  );
  adcpo_capture adcpo_capture_i (
    .i_strobe(strobe), .i_word(word), .i_flag(flag), .i_accept(accept),
    .o_capture_ready(ready), .o_word(cap_word), .o_flag(cap_flag), .o_count(cap_n)
  );
  function automatic logic [15:0] expv(logic [15:0] p, logic [15:0] n);
    logic signed [16:0] d;
    d = $signed({p[15], p}) - $signed({n[15], n});
    if (d > 17'sh03fff) return {1'b1, 15'h3fff};
    if (d < -17'sh04000) return {1'b1, 15'h4000};
    return {1'b0, d[14:0]};
  endfunction
  task wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wait_ph(input logic [3:0] k);
    int n;
    n = 0;
    while (ph !== k && n < 40) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      wrap_up;
    end
  endtask
  task step(input logic [15:0] p, input logic [15:0] n);
    wait_ph(4'ha);
    ain_p <= p;
    ain_n <= n;
    @(posedge i_mclk);
  endtask
  task do_reset;
    checking = 1'b0;
    exp_q.delete();
    wait_ph(4'h8);
    i_rst_b <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    checking = 1'b1;
  endtask
  task t_coding;
    logic [31:0] tbl[8];
    int i;
    tbl = '{32'h3fff_0000, 32'h4000_0000, 32'h0000_0000, 32'h0000_0001,
            32'h0000_4000, 32'h0000_4001, 32'h7fff_8000, 32'h1234_0111};
    for (i = 0; i < 8; i++) step(tbl[i][31:16], tbl[i][15:0]);
    repeat (6 * 16) @(posedge i_mclk);
    `ADCPO_CHK("backlog", 1'b1, exp_q.size() inside {3, 4})
    `ADCPO_CHK("no drop", 1'b0, drop)
  endtask
  task t_stall;
    int n0, drops, i;
    checking = 1'b0;
    drops = 0;
    accept <= 1'b0;
    repeat (4 * 16) @(posedge i_mclk);
    n0 = cap_n;
    for (i = 0; i < 6 * 16; i++) begin
      @(posedge i_mclk);
      if (drop === 1'b1) drops++;
    end
    `ADCPO_CHK("held", n0, cap_n)
    `ADCPO_CHK("drop seen", 1'b1, drops > 0)
    accept <= 1'b1;
    repeat (4 * 16) @(posedge i_mclk);
    `ADCPO_CHK("resumed", 1'b1, cap_n >= n0 + 2)
  endtask
  task t_duty;
    hi_cyc <= 4'h5;
    repeat (4 * 16) @(posedge i_mclk);
    `ADCPO_CHK("duty fault", 1'b1, duty)
    hi_cyc <= 4'h8;
    repeat (3 * 16) @(posedge i_mclk);
    `ADCPO_CHK("duty fault", 1'b0, duty)
  endtask
  initial begin
    do_reset;
    t_coding;
    t_stall;
    do_reset;
    t_duty;
    wrap_up;
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up;
  end
endmodule // adc_parallel_sample_output_tb_top

// >>> adcpo_buf2.v
`timescale 1ns/1ps
module adcpo_buf2 #(
  parameter WIDTH = 16
) (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  // ************************************************************
  // Two-entry queue with honest full and empty.
  // ************************************************************
  assign o_in_ready = (count_r != 2'd2);
  assign o_out_valid = (count_r != 2'd0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'd1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'd1;
      end
    end
  end

endmodule // adcpo_buf2

// >>> adcpo_capture.sv
`timescale 1ns/1ps
`include "adcpo_regs.vh"
module adcpo_capture (
  input wire i_strobe,
  input wire [`ADCPO_WORD_W-1:0] i_word,
  input wire i_flag,
  input wire i_accept,
  output wire o_capture_ready,
  output logic [`ADCPO_WORD_W-1:0] o_word,
  output logic o_flag,
  output int o_count
);
  // Ready follows the bench, so a stall happens only when a scenario asks.
  assign o_capture_ready = i_accept;
  initial o_count = 0;
  always @(posedge i_strobe) begin
    o_word <= i_word;
    o_flag <= i_flag;
    o_count <= o_count + 1;
  end
endmodule // adcpo_capture

// >>> adcpo_regs.vh
`ifndef ADCPO_REGS_VH
`define ADCPO_REGS_VH

// ************************************************************
// Sample format
// ************************************************************
`define ADCPO_WORD_W 15
`define ADCPO_WORD_MSB 14
`define ADCPO_IN_W 16
`define ADCPO_DIFF_W 17
`define ADCPO_POS_FULL 17'h03fff
`define ADCPO_NEG_FULL 17'h1c000
`define ADCPO_POS_CODE 15'h3fff
`define ADCPO_NEG_CODE 15'h4000
`define ADCPO_WORD_RST 15'h0000

// ************************************************************
// Timing
// ************************************************************
`define ADCPO_MCLK_PERIOD_PS 5000
`define ADCPO_STROBE_DELAY_PS 6500
// The strobe delay is rounded up to whole system clock cycles.
`define ADCPO_STROBE_DELAY_CYC 3'h2
`define ADCPO_DLY_W 3
`define ADCPO_DUTY_W 8
`define ADCPO_DUTY_TOL_PCT 16'h000a
`define ADCPO_DUTY_MAX 8'hff

`endif

// >>> adcpo_sync.v
`timescale 1ns/1ps
module adcpo_sync #(
  parameter WIDTH = 1
) (
  input wire i_mclk,
  input wire i_rst_b,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_r;

  // ************************************************************
  // Two flops; the first is read only by the second.
  // ************************************************************
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      meta_r <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // adcpo_sync

// >>> adcpo_top.v
`timescale 1ns/1ps
`include "adcpo_regs.vh"

// Behaviour
// - Sample input on conversion clock rising edge.
// - Word appears three conversion clocks after sampling.
// - Word stable at each strobe rising edge.
// - Strobe rises a delay after clock fall.
// - Fifteen-bit two's-complement word, bit 14 MSB.
// - Positive full scale gives 0 then ones.
// - Negative full scale gives 1 then zeros.
// - Overrange flag high beyond either full scale.
// - Overrange flag timed exactly like the word.
// - Overrange flag low inside full-scale range.
module adcpo_top (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_conv_clock_pos,
  input wire i_conv_clock_neg,
  input wire [`ADCPO_IN_W-1:0] i_analog_in_pos,
  input wire [`ADCPO_IN_W-1:0] i_analog_in_neg,
  input wire i_capture_ready,
  output reg [`ADCPO_WORD_W-1:0] o_sample_word,
  output reg o_overrange_flag,
  output reg o_sample_valid_strobe,
  output reg o_duty_fault,
  output reg o_sample_dropped
);

  localparam [`ADCPO_DLY_W-1:0] STROBE_DLY = `ADCPO_STROBE_DELAY_CYC;
  localparam [`ADCPO_DUTY_W-1:0] DUTY_MAX = `ADCPO_DUTY_MAX;
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT_FALL = 2'd1;
  localparam [1:0] ST_DELAY = 2'd2;
  localparam [1:0] ST_HIGH = 2'd3;
  localparam ENT_W = `ADCPO_WORD_W + 1;
  localparam [`ADCPO_WORD_W-1:0] CODE_POS = `ADCPO_POS_CODE;
  localparam [`ADCPO_WORD_W-1:0] CODE_NEG = `ADCPO_NEG_CODE;
  localparam [1:0] SETTLE_DONE = 2'h3;

  // ************************************************************
  // Quantiser: difference, clamp and overrange in one place.
  // ************************************************************
  function [ENT_W-1:0] adcpo_code;
    input [`ADCPO_IN_W-1:0] pos;
    input [`ADCPO_IN_W-1:0] neg;
    reg [`ADCPO_DIFF_W-1:0] diff;
    reg over_hi;
    reg over_lo;
    begin
      diff = {pos[`ADCPO_IN_W-1], pos} - {neg[`ADCPO_IN_W-1], neg};
      over_hi = !diff[`ADCPO_DIFF_W-1] && (diff > `ADCPO_POS_FULL);
      over_lo = diff[`ADCPO_DIFF_W-1] && (diff < `ADCPO_NEG_FULL);
      if (over_hi) begin
        adcpo_code = {1'b1, CODE_POS};
      end else if (over_lo) begin
        adcpo_code = {1'b1, CODE_NEG};
      end else begin
        adcpo_code = {1'b0, diff[`ADCPO_WORD_W-1:0]};
      end
    end
  endfunction

  // ************************************************************
  // Input crossing: clock and analog codes pass two flops.
  // ************************************************************
  wire [1:0] clk_sync;
  wire [`ADCPO_IN_W-1:0] in_pos_sync;
  wire [`ADCPO_IN_W-1:0] in_neg_sync;
  wire ready_sync;

  adcpo_sync #(.WIDTH(3)) u_sync_ctl (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async({i_capture_ready, i_conv_clock_pos, i_conv_clock_neg}),
    .o_sync({ready_sync, clk_sync})
  );

  // The analog codes are assumed to settle well before the clock edge, as a
  // real sampler would see them; a multi-bit flop pair is only safe then.
  adcpo_sync #(.WIDTH(2 * `ADCPO_IN_W)) u_sync_in (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async({i_analog_in_pos, i_analog_in_neg}),
    .o_sync({in_pos_sync, in_neg_sync})
  );

  // ************************************************************
  // Conversion clock edges.
  // ************************************************************
  reg conv_lvl_r;
  reg [1:0] settle_r;
  reg armed_r;
  wire conv_lvl_nxt;
  wire conv_rise;
  wire conv_fall;

  assign conv_lvl_nxt = clk_sync[1] & ~clk_sync[0];
  assign conv_rise = conv_lvl_nxt & ~conv_lvl_r & armed_r;
  assign conv_fall = ~conv_lvl_nxt & conv_lvl_r & armed_r;

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      conv_lvl_r <= 1'b0;
    end else begin
      conv_lvl_r <= conv_lvl_nxt;
    end
  end

  // ************************************************************
  // Edge arming after reset.
  // ************************************************************
  // The synchroniser reads zero for two cycles after reset, so a clock that
  // is already high would pass for a fresh rise and a short first sample;
  // edges count only once the flops have settled and the clock was low.
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      settle_r <= 2'h0;
      armed_r <= 1'b0;
    end else begin
      if (settle_r != SETTLE_DONE) begin
        settle_r <= settle_r + 2'h1;
      end
      if ((settle_r == SETTLE_DONE) && !conv_lvl_nxt) begin
        armed_r <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Pipeline: sample, one stage, then the buffer.
  // ************************************************************
  reg [ENT_W-1:0] stage0_r;
  reg [ENT_W-1:0] stage1_r;
  reg [1:0] stage_vld_r;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [ENT_W-1:0] buf_out_data;
  wire buf_push;
  wire buf_pop;
  wire out_free;

  // A full buffer halts the pipe; a converter cannot pause, so the sample
  // taken at that edge is lost and reported rather than silently skipped.
  assign buf_push = conv_rise & stage_vld_r[1];

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      stage0_r <= {ENT_W{1'b0}};
      stage1_r <= {ENT_W{1'b0}};
      stage_vld_r <= 2'b00;
      o_sample_dropped <= 1'b0;
    end else if (conv_rise) begin
      o_sample_dropped <= !buf_in_ready && stage_vld_r[1];
      if (buf_in_ready || !stage_vld_r[1]) begin
        stage0_r <= adcpo_code(in_pos_sync, in_neg_sync);
        stage1_r <= stage0_r;
        stage_vld_r <= {stage_vld_r[0], 1'b1};
      end
    end
  end

  adcpo_buf2 #(.WIDTH(ENT_W)) u_buf (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_in_valid(buf_push),
    .o_in_ready(buf_in_ready),
    .i_in_data(stage1_r),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_pop),
    .o_out_data(buf_out_data)
  );

  // ************************************************************
  // Output stage and strobe timing.
  // ************************************************************
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [`ADCPO_DLY_W-1:0] dly_r;
  reg [`ADCPO_DLY_W-1:0] dly_nxt;

  assign out_free = ready_sync;
  assign buf_pop = conv_rise & buf_out_valid & out_free;

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_sample_word <= `ADCPO_WORD_RST;
      o_overrange_flag <= 1'b0;
    end else if (buf_pop) begin
      // Word and flag change together on the rising edge only.
      o_sample_word <= buf_out_data[`ADCPO_WORD_W-1:0];
      o_overrange_flag <= buf_out_data[ENT_W-1];
    end
  end

  always @* begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    case (st_r)
      ST_IDLE: begin
        if (buf_pop) begin
          st_nxt = ST_WAIT_FALL;
        end
      end
      ST_WAIT_FALL: begin
        if (conv_fall) begin
          st_nxt = ST_DELAY;
          dly_nxt = STROBE_DLY;
        end
      end
      ST_DELAY: begin
        if (dly_r <= 3'd1) begin
          st_nxt = ST_HIGH;
        end else begin
          dly_nxt = dly_r - 3'd1;
        end
      end
      ST_HIGH: begin
        if (buf_pop) begin
          st_nxt = ST_WAIT_FALL;
        end else if (conv_rise) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      dly_r <= 3'd0;
      o_sample_valid_strobe <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      // Strobe rises the strobe delay after the clock fall, more than half a cycle after the data change, so both edges of
      // the word sit far from its rising edge.
      o_sample_valid_strobe <= (st_nxt == ST_HIGH);
    end
  end

  // ************************************************************
  // Conversion clock duty monitor.
  // ************************************************************
  reg [`ADCPO_DUTY_W-1:0] hi_cnt_r;
  reg [`ADCPO_DUTY_W-1:0] lo_cnt_r;
  reg seen_fall_r;
  wire [`ADCPO_DUTY_W:0] duty_diff;
  wire [`ADCPO_DUTY_W+7:0] duty_lhs;
  wire [`ADCPO_DUTY_W+7:0] duty_rhs;

  assign duty_diff = (hi_cnt_r > lo_cnt_r) ? {1'b0, hi_cnt_r - lo_cnt_r}
                                           : {1'b0, lo_cnt_r - hi_cnt_r};
  assign duty_lhs = {7'h00, duty_diff} * 15'd100;
  assign duty_rhs = ({8'h00, hi_cnt_r} + {8'h00, lo_cnt_r}) *
                    `ADCPO_DUTY_TOL_PCT;

  // Only a coarse check: at 200 MHz one sample is five ns, so short clock
  // periods cannot resolve a five percent error.
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      hi_cnt_r <= 8'h00;
      lo_cnt_r <= 8'h00;
      seen_fall_r <= 1'b0;
      o_duty_fault <= 1'b0;
    end else if (conv_rise) begin
      if (seen_fall_r) begin
        o_duty_fault <= (duty_lhs > duty_rhs);
      end
      hi_cnt_r <= 8'h01;
      lo_cnt_r <= 8'h00;
      seen_fall_r <= 1'b0;
    end else if (conv_lvl_nxt) begin
      if (hi_cnt_r != DUTY_MAX) begin
        hi_cnt_r <= hi_cnt_r + 8'h01;
      end
    end else begin
      seen_fall_r <= seen_fall_r | conv_fall;
      if (lo_cnt_r != DUTY_MAX) begin
        lo_cnt_r <= lo_cnt_r + 8'h01;
      end
    end
  end

endmodule // adcpo_top

// >>> adcpo_top_sva.sv
`timescale 1ns/1ps
`include "adcpo_regs.vh"
module adcpo_top_sva (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_conv_clock_pos,
  input wire [`ADCPO_WORD_W-1:0] o_sample_word,
  input wire o_overrange_flag,
  input wire o_sample_valid_strobe,
  input wire o_sample_dropped
);
  // ****
  // Checks.
  // ****
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  property p_hold;
    o_sample_valid_strobe && $past(o_sample_valid_strobe) |-> $stable(o_sample_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved under strobe");
  property p_word_edge;
    !$stable(o_sample_word) |-> $past(i_conv_clock_pos) && !o_sample_valid_strobe;
  endproperty
  a_word_edge: assert property (p_word_edge) else $error("word moved off edge");
  property p_flag_edge;
    !$stable(o_overrange_flag) |-> $past(i_conv_clock_pos) && !o_sample_valid_strobe;
  endproperty
  a_flag_edge: assert property (p_flag_edge) else $error("flag moved off edge");
  property p_clip;
    o_overrange_flag |-> o_sample_word == 15'h3fff || o_sample_word == 15'h4000;
  endproperty
  a_clip: assert property (p_clip) else $error("flag without clip");
  property p_rise;
    $rose(o_sample_valid_strobe) |-> !$past(i_conv_clock_pos, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("strobe rose early");
  property p_fall;
    $fell(o_sample_valid_strobe) |-> $past(i_conv_clock_pos);
  endproperty
  a_fall: assert property (p_fall) else $error("strobe fell off edge");
  property p_once;
    $rose(o_sample_valid_strobe) |=> (!$rose(o_sample_valid_strobe)) [*8];
  endproperty
  a_once: assert property (p_once) else $error("strobe too often");
  property p_drop;
    $rose(o_sample_dropped) |-> !o_sample_valid_strobe;
  endproperty
  a_drop: assert property (p_drop) else $error("drop while strobing");
endmodule // adcpo_top_sva
bind adcpo_top adcpo_top_sva adcpo_top_sva_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_conv_clock_pos(i_conv_clock_pos),
  .o_sample_word(o_sample_word), .o_overrange_flag(o_overrange_flag),
  .o_sample_valid_strobe(o_sample_valid_strobe), .o_sample_dropped(o_sample_dropped)
);
